// ---- byte_reg.sv ----
`timescale 1ns/1ns
`default_nettype none
module byte_reg #(
    parameter int WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic load,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] q
);
    // Without reset on purpose: contents are undefined until written.
    always_ff @(posedge ref_clk)
    begin
        if (load)
        begin
            q <= din; // RULE5
        end
    end
endmodule : byte_reg
`default_nettype wire

// ---- core_regs.sv ----
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ns
`default_nettype none
module core_regs #(
    parameter int DATA_WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [3:0] addr,
    input wire logic [DATA_WIDTH-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_WIDTH-1:0] rdata,
    output logic vec_req,
    output logic [15:0] vec_addr,
    input wire logic [DATA_WIDTH-1:0] vec_data,
    input wire logic vec_valid,
    output logic core_ready
);
    vector_bus_if vbus ();
    logic [DATA_WIDTH-1:0] acc_q, xi_q, yi_q, sp_q, st_q;
    logic [DATA_WIDTH-1:0] counter_low_byte, counter_high_byte;
    core_regs_pkg::boot_state_type boot_state;

    assign vbus.rdata = vec_data;
    assign vbus.rvalid = vec_valid;
    assign vec_req = vbus.req;
    assign vec_addr = vbus.addr;

    // ----------------------------------------------------------------
    // General registers
    // ----------------------------------------------------------------
    byte_reg #(.WIDTH(DATA_WIDTH)) acc_reg (.ref_clk(ref_clk),
        .load(wr && addr == core_regs_pkg::ADDR_ACCUMULATOR), .din(wdata), .q(acc_q)); // RULE1
    byte_reg #(.WIDTH(DATA_WIDTH)) xi_reg (.ref_clk(ref_clk),
        .load(wr && addr == core_regs_pkg::ADDR_FIRST_INDEX), .din(wdata), .q(xi_q)); // RULE1
    byte_reg #(.WIDTH(DATA_WIDTH)) yi_reg (.ref_clk(ref_clk),
        .load(wr && addr == core_regs_pkg::ADDR_SECOND_INDEX), .din(wdata), .q(yi_q)); // RULE1
    byte_reg #(.WIDTH(DATA_WIDTH)) sp_reg (.ref_clk(ref_clk),
        .load(wr && addr == core_regs_pkg::ADDR_STACK_POINTER), .din(wdata), .q(sp_q)); // RULE1

    // ----------------------------------------------------------------
    // Status flags: only the interrupt-disable bit has a reset value.
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (wr && addr == core_regs_pkg::ADDR_STATUS_FLAGS)
        begin
            st_q <= wdata; // RULE5
        end
    end

    logic irq_disable;
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            irq_disable <= 1'b1; // RULE3
        end
        else if (wr && addr == core_regs_pkg::ADDR_STATUS_FLAGS)
        begin
            irq_disable <= wdata[core_regs_pkg::IRQ_DISABLE_BIT];
        end
    end

    logic [DATA_WIDTH-1:0] status_flags;
    always_comb
    begin
        status_flags = st_q;
        status_flags[core_regs_pkg::IRQ_DISABLE_BIT] = irq_disable;
    end

    // ----------------------------------------------------------------
    // Boot sequence: fetch the vector, then run.
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            boot_state <= core_regs_pkg::FETCH_LOW;
        end
        else
        begin
            unique case (boot_state)
                core_regs_pkg::FETCH_LOW:
                begin
                    if (vbus.rvalid)
                    begin
                        boot_state <= core_regs_pkg::FETCH_HIGH;
                    end
                end
                core_regs_pkg::FETCH_HIGH:
                begin
                    if (vbus.rvalid)
                    begin
                        boot_state <= core_regs_pkg::RUNNING; // RULE4
                    end
                end
                core_regs_pkg::RUNNING:
                begin
                    boot_state <= core_regs_pkg::RUNNING;
                end
                default:
                begin
                    boot_state <= core_regs_pkg::FETCH_LOW;
                end
            endcase
        end
    end

    assign vbus.req = (boot_state != core_regs_pkg::RUNNING);
    assign vbus.addr = (boot_state == core_regs_pkg::FETCH_HIGH) ?
        core_regs_pkg::RESET_VECTOR_HIGH : core_regs_pkg::RESET_VECTOR_LOW; // RULE7
    assign core_ready = (boot_state == core_regs_pkg::RUNNING);

    // ----------------------------------------------------------------
    // Program counter halves
    // ----------------------------------------------------------------
    // Software writes are ignored until the vector is in, so the fetch wins.
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            counter_low_byte <= '0;
        end
        else if (boot_state == core_regs_pkg::FETCH_LOW && vbus.rvalid)
        begin
            counter_low_byte <= vbus.rdata; // RULE7
        end
        else if (core_ready && wr && addr == core_regs_pkg::ADDR_COUNTER_LOW)
        begin
            counter_low_byte <= wdata; // RULE2
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            counter_high_byte <= '0;
        end
        else if (boot_state == core_regs_pkg::FETCH_HIGH && vbus.rvalid)
        begin
            counter_high_byte <= vbus.rdata; // RULE4
        end
        else if (core_ready && wr && addr == core_regs_pkg::ADDR_COUNTER_HIGH)
        begin
            counter_high_byte <= wdata; // RULE2
        end
    end

    logic [15:0] program_counter;
    assign program_counter = {counter_high_byte, counter_low_byte}; // RULE2

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rdata <= '0;
        end
        else if (rd)
        begin
            unique case (addr)
                core_regs_pkg::ADDR_ACCUMULATOR: rdata <= acc_q;
                core_regs_pkg::ADDR_FIRST_INDEX: rdata <= xi_q;
                core_regs_pkg::ADDR_SECOND_INDEX: rdata <= yi_q;
                core_regs_pkg::ADDR_STACK_POINTER: rdata <= sp_q;
                core_regs_pkg::ADDR_STATUS_FLAGS: rdata <= status_flags;
                core_regs_pkg::ADDR_COUNTER_LOW: rdata <= program_counter[7:0];
                core_regs_pkg::ADDR_COUNTER_HIGH: rdata <= program_counter[15:8];
                core_regs_pkg::ADDR_CORE_STATE: rdata <= {{(DATA_WIDTH-1){1'b0}}, core_ready};
                default: rdata <= '0;
            endcase
        end
        else
        begin
            rdata <= '0;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // The reset low time is the reset source's duty; the core only relies on it.
    // Starts from zero so the first release after power-up is judged, not unknown.
    int unsigned low_count = 0;
    always_ff @(posedge ref_clk)
    begin
        low_count <= rstn ? 0 : low_count + 1; // RULE6
    end

    irq_after_reset_a: assert property (@(posedge ref_clk) $rose(rstn) |->
        irq_disable) else $error("Interrupt disable not set after reset."); // RULE3
    vector_order_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        boot_state == core_regs_pkg::FETCH_LOW |-> vbus.addr == core_regs_pkg::RESET_VECTOR_LOW)
        else $error("Wrong low vector address."); // RULE7
    high_fetch_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        boot_state == core_regs_pkg::FETCH_HIGH && vbus.rvalid |=>
        counter_high_byte == $past(vbus.rdata) && core_ready)
        else $error("High vector byte not loaded."); // RULE4
    low_fetch_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        boot_state == core_regs_pkg::FETCH_LOW && vbus.rvalid |=>
        counter_low_byte == $past(vbus.rdata) && vbus.addr == core_regs_pkg::RESET_VECTOR_HIGH)
        else $error("Low vector byte not loaded."); // RULE7
    pc_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        core_ready && !wr |=> $stable(program_counter))
        else $error("Counter changed without a write."); // RULE2
    acc_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr && addr == core_regs_pkg::ADDR_ACCUMULATOR ##1 rd &&
        addr == core_regs_pkg::ADDR_ACCUMULATOR |=> rdata == $past(wdata, 2))
        else $error("Accumulator readback mismatch."); // RULE1
    status_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr && addr == core_regs_pkg::ADDR_STATUS_FLAGS |=>
        irq_disable == $past(wdata[core_regs_pkg::IRQ_DISABLE_BIT]))
        else $error("Status bit not written."); // RULE3
    idle_read_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !rd |=> rdata == '0) else $error("Read data not cleared."); // RULE1
    fetch_req_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !core_ready |-> vbus.req) else $error("Vector request missing."); // RULE4
    pc_refused_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        boot_state == core_regs_pkg::FETCH_LOW && !vbus.rvalid |=>
        $stable(counter_low_byte)) else $error("Counter written during boot."); // RULE4
    status_read_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        rd && addr == core_regs_pkg::ADDR_STATUS_FLAGS |=>
        rdata[core_regs_pkg::IRQ_DISABLE_BIT] == $past(irq_disable))
        else $error("Status read mismatch."); // RULE3
    ready_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        core_ready |=> core_ready) else $error("Core left running state."); // RULE4
    reset_width_a: assert property (@(posedge ref_clk) $rose(rstn) |->
        $past(low_count) >= 20) else $error("Reset pulse too short."); // RULE6

endmodule : core_regs
`default_nettype wire

// ---- core_regs_pkg.sv ----
// How it works
// RULE1: Five CPU registers are eight bits wide.
// RULE2: Program counter is two bytes, sixteen bits.
// RULE3: Reset sets interrupt-disable flag, status bit two.
// RULE4: After reset, counter loads from vector FFFA/FFFB.
// RULE5: Other registers need no reset value.
// RULE6: Reset input held low over twenty cycles.
// RULE7: Low byte from lower vector address.
`default_nettype none
package core_regs_pkg;

    // ----------------------------------------------------------------
    // Register port map
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_ACCUMULATOR = 4'h0;
    localparam logic [3:0] ADDR_FIRST_INDEX = 4'h1;
    localparam logic [3:0] ADDR_SECOND_INDEX = 4'h2;
    localparam logic [3:0] ADDR_STACK_POINTER = 4'h3;
    localparam logic [3:0] ADDR_STATUS_FLAGS = 4'h4;
    localparam logic [3:0] ADDR_COUNTER_LOW = 4'h5;
    localparam logic [3:0] ADDR_COUNTER_HIGH = 4'h6;
    localparam logic [3:0] ADDR_CORE_STATE = 4'h7;

    // ----------------------------------------------------------------
    // Fields, vectors and timing
    // ----------------------------------------------------------------
    localparam int IRQ_DISABLE_BIT = 2;
    localparam logic [15:0] RESET_VECTOR_LOW = 16'hFFFA;
    localparam logic [15:0] RESET_VECTOR_HIGH = 16'hFFFB;
    localparam int CLOCK_MHZ = 125;
    localparam int MIN_RESET_LOW_CYCLES = 20;
    localparam int RESET_LOW_US = 2;
    localparam int RESET_LOW_CLOCKS = RESET_LOW_US * CLOCK_MHZ;

    typedef enum logic [1:0]
    {
        FETCH_LOW,
        FETCH_HIGH,
        RUNNING
    } boot_state_type;

endpackage : core_regs_pkg
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, want) begin n_tests++; if ((got) !== (want)) begin errors++; $display("unexpected at %0t: got %h want %h", $time, got, want); end end
module testbench;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic vec_req;
    logic [15:0] vec_addr;
    logic [7:0] vec_data = 8'h00;
    logic vec_valid = 1'b0;
    logic core_ready;
    logic vec_idx = 1'b0;
    logic [7:0] vec_lo = 8'h34;
    logic [7:0] vec_hi = 8'h12;
    logic [7:0] got;
    logic [7:0] pat [0:4] = '{8'hA5, 8'h5A, 8'hFF, 8'h7E, 8'h81};
    int errors = 0;
    int n_tests = 0;
    int cycles = 0;

    core_regs dut (.ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .vec_req(vec_req), .vec_addr(vec_addr), .vec_data(vec_data),
        .vec_valid(vec_valid), .core_ready(core_ready));

    always #4 ref_clk = ~ref_clk;

    // ----------------------------------------------------------------
    // Vector memory model
    // ----------------------------------------------------------------
    // Between bytes the data lines wander so a stale byte is never mistaken for a fresh one.
    always @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            vec_valid <= 1'b0;
            vec_idx <= 1'b0;
        end
        else if (vec_req && !vec_valid)
        begin
            `CHK(vec_addr, vec_idx ? 16'hFFFB : 16'hFFFA)
            vec_valid <= 1'b1;
            vec_data <= vec_idx ? vec_hi : vec_lo;
            vec_idx <= ~vec_idx;
        end
        else
        begin
            vec_valid <= 1'b0;
            vec_data <= ~vec_data;
        end
    end

    // ----------------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------------
    task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask : write_reg

    task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : read_reg

    // The reset is held past the twenty-cycle minimum that the core demands.
    task automatic do_reset(input logic [7:0] lo, input logic [7:0] hi);
        int n;
        vec_lo = lo;
        vec_hi = hi;
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (22) @(posedge ref_clk);
        #1;
        `CHK(vec_req, 1'b1)
        `CHK(vec_addr, 16'hFFFA)
        `CHK(core_ready, 1'b0)
        rstn <= 1'b1;
        write_reg(core_regs_pkg::ADDR_COUNTER_LOW, 8'hEE);
        n = 0;
        while (core_ready !== 1'b1 && n < 20)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        `CHK(core_ready, 1'b1)
        read_reg(core_regs_pkg::ADDR_COUNTER_LOW, got);
        `CHK(got, lo)
        read_reg(core_regs_pkg::ADDR_COUNTER_HIGH, got);
        `CHK(got, hi)
        read_reg(core_regs_pkg::ADDR_STATUS_FLAGS, got);
        `CHK(got[core_regs_pkg::IRQ_DISABLE_BIT], 1'b1)
        read_reg(core_regs_pkg::ADDR_CORE_STATE, got);
        `CHK(got[0], 1'b1)
    endtask : do_reset

    task automatic test_done;
        $display("errors %0d tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            $display("unexpected at %0t: run did not finish", $time);
            test_done;
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        do_reset(8'h34, 8'h12);
        for (int i = 0; i < 5; i++)
            write_reg(4'(i), pat[i]);
        for (int i = 0; i < 5; i++)
        begin
            read_reg(4'(i), got);
            `CHK(got, pat[i])
        end
        @(posedge ref_clk);
        #1;
        `CHK(rdata, 8'h00)
        // Write then read the accumulator on back-to-back strobes.
        @(posedge ref_clk);
        wr <= 1'b1;
        addr <= core_regs_pkg::ADDR_ACCUMULATOR;
        wdata <= 8'h3C;
        @(posedge ref_clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        `CHK(rdata, 8'h3C)
        write_reg(core_regs_pkg::ADDR_COUNTER_LOW, 8'hC3);
        write_reg(core_regs_pkg::ADDR_COUNTER_HIGH, 8'h3C);
        read_reg(core_regs_pkg::ADDR_COUNTER_LOW, got);
        `CHK(got, 8'hC3)
        read_reg(core_regs_pkg::ADDR_COUNTER_HIGH, got);
        `CHK(got, 8'h3C)
        write_reg(4'h9, 8'h55);
        read_reg(4'h9, got);
        `CHK(got, 8'h00)
        read_reg(4'hF, got);
        `CHK(got, 8'h00)
        // A second reset with the interrupt-disable bit cleared beforehand.
        do_reset(8'h01, 8'h80);
        test_done;
    end
endmodule : testbench
`default_nettype wire

// ---- vector_bus_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface vector_bus_if;
    logic req;
    logic [15:0] addr;
    logic [7:0] rdata;
    logic rvalid;
    modport master (output req, output addr, input rdata, input rvalid);
    modport slave (input req, input addr, output rdata, output rvalid);
endinterface : vector_bus_if
`default_nettype wire
